/* rtl/rfc_pkg.sv */
// Package of constants for the relay function controller
`default_nettype none
package rfc_pkg;
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned SEC_NS = 1000000000;
	localparam int unsigned SEC_CYCLES = SEC_NS / CLK_PERIOD_NS;
	localparam int unsigned AW = 8;
	localparam int unsigned DW = 32;
	localparam int unsigned VW = 16;
	localparam int unsigned TW = 17;
	localparam int unsigned DIVW = 25;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ALARM_HI = 8'h04;
	localparam logic [7:0] OFS_ALARM_LO = 8'h08;
	localparam logic [7:0] OFS_HYST = 8'h0C;
	localparam logic [7:0] OFS_PUMP_ON = 8'h10;
	localparam logic [7:0] OFS_PUMP_OFF = 8'h14;
	localparam logic [7:0] OFS_AMOUNT = 8'h18;
	localparam logic [7:0] OFS_INTERVAL = 8'h1C;
	localparam logic [7:0] OFS_OFF_DELAY = 8'h20;
	localparam logic [7:0] OFS_ACT_TIME = 8'h24;
	localparam logic [7:0] OFS_DURATION = 8'h28;
	localparam logic [7:0] OFS_SPAN = 8'h2C;
	localparam logic [7:0] OFS_STATUS = 8'h30;
	localparam logic [7:0] OFS_ACCUM = 8'h34;
	// Control register fields
	localparam int unsigned CTRL_MODE_LSB = 0;
	localparam int unsigned MODE_W = 3;
	localparam int unsigned CTRL_INV = 3;
	localparam int unsigned CTRL_FS_EN = 4;
	localparam int unsigned CTRL_FS_STATE = 5;
	localparam int unsigned CTRL_CMD = 6;
	localparam int unsigned CTRL_TIMED = 7;
	localparam int unsigned CTRL_KIND_LSB = 8;
	localparam int unsigned CTRL_W = 10;
	localparam logic [9:0] CTRL_RST = 10'h000;
	// Functions
	localparam logic [2:0] MODE_OFF = 3'h0;
	localparam logic [2:0] MODE_ALARM = 3'h1;
	localparam logic [2:0] MODE_PUMP = 3'h2;
	localparam logic [2:0] MODE_TOT = 3'h3;
	localparam logic [2:0] MODE_SAMP = 3'h4;
	localparam logic [2:0] MODE_TOD = 3'h5;
	localparam logic [2:0] MODE_ELAPSED = 3'h6;
	localparam logic [2:0] MODE_BASIC = 3'h7;
	localparam logic [3:0] MODE_APP_SETUP = 4'h8;
	// Alarm kinds
	localparam logic [1:0] KIND_HIGH = 2'h0;
	localparam logic [1:0] KIND_LOW = 2'h1;
	localparam logic [1:0] KIND_IN = 2'h2;
	localparam logic [1:0] KIND_OUT = 2'h3;
	// Fixed bounds hysteresis as a fraction of span
	localparam int unsigned BOUNDS_PCT = 2;
	localparam int unsigned PCT_DEN = 100;
	// Status fields
	localparam int unsigned ST_COIL = 0;
	localparam int unsigned ST_FUNC = 1;
	localparam int unsigned ST_BUSY = 2;
	localparam int unsigned ST_HI = 3;
	localparam int unsigned ST_LO = 4;
	localparam int unsigned ST_PUMP = 5;
	localparam int unsigned ST_FS = 6;
	localparam int unsigned ST_MODE_LSB = 8;
	// Pulse timer states
	typedef enum logic [2:0] {
		PS_IDLE = 3'b001,
		PS_ACTIVE = 3'b010,
		PS_GAP = 3'b100
	} rfc_pstate_e;
endpackage
`default_nettype wire

/* rtl/rfc_pulse_if.sv */
// Interface between the controller and its pulse timer
`default_nettype none
interface rfc_pulse_if;
	logic tick;
	logic trig;
	logic [15:0] len;
	logic active;
	logic busy;
	modport owner (output tick, output trig, output len, input active, input busy);
	modport timer (input tick, input trig, input len, output active, output busy);
endinterface
`default_nettype wire

/* rtl/rfc_pulse.sv */
// Second-based pulse timer with equal closed and open phases
`default_nettype none
module rfc_pulse (
	input wire logic i_clk,
	input wire logic i_rst,
	rfc_pulse_if.timer p
);
	rfc_pkg::rfc_pstate_e state;
	logic [15:0] cnt;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state <= rfc_pkg::PS_IDLE;
			cnt <= 16'h0000;
		end else begin
			case (state)
				rfc_pkg::PS_IDLE: begin
					if (p.trig && p.len != 16'h0000) begin
						state <= rfc_pkg::PS_ACTIVE;
						cnt <= p.len;
					end
				end
				rfc_pkg::PS_ACTIVE: begin
					if (p.tick) begin
						cnt <= cnt - 16'h0001;
						if (cnt == 16'h0001) begin
							state <= rfc_pkg::PS_GAP;
							cnt <= p.len;
						end
					end
				end
				rfc_pkg::PS_GAP: begin
					if (p.tick) begin
						cnt <= cnt - 16'h0001;
						if (cnt <= 16'h0001) begin
							state <= rfc_pkg::PS_IDLE;
						end
					end
				end
				default: begin
					state <= rfc_pkg::PS_IDLE;
				end
			endcase
		end
	end

	assign p.active = (state == rfc_pkg::PS_ACTIVE);
	assign p.busy = (state != rfc_pkg::PS_IDLE);
endmodule
`default_nettype wire

/* rtl/rfc_alarm.sv */
// High and low limit alarms with hysteresis
`default_nettype none
module rfc_alarm (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [15:0] i_level,
	input wire logic [15:0] i_hi,
	input wire logic [15:0] i_lo,
	input wire logic [15:0] i_hyst,
	output logic o_hi,
	output logic o_lo
);
	logic [16:0] hi_clr;
	logic [16:0] lo_clr;

	assign hi_clr = {1'b0, i_hi} - {1'b0, i_hyst};
	assign lo_clr = {1'b0, i_lo} + {1'b0, i_hyst};

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_hi <= 1'b0;
		end else if (i_level >= i_hi) begin
			o_hi <= 1'b1;
		end else if (!hi_clr[16] && {1'b0, i_level} < hi_clr) begin
			o_hi <= 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_lo <= 1'b0;
		end else if (i_level <= i_lo) begin
			o_lo <= 1'b1;
		end else if ({1'b0, i_level} > lo_clr) begin
			o_lo <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* rtl/rfc_relay_ctrl.sv */
// Relay function controller: one relay, its functions, fail-safe and polarity
//
// The register addresses and the strobed register port are this design's own decisions.
`default_nettype none
module rfc_relay_ctrl #(
	parameter int unsigned CYCLES_PER_SEC = rfc_pkg::SEC_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire logic [15:0] i_level,
	input wire logic i_level_bad,
	input wire logic i_failsafe,
	input wire logic [15:0] i_qty_inc,
	input wire logic i_qty_valid,
	input wire logic [16:0] i_tod_sec,
	output logic o_coil,
	output logic o_icon
);
	logic [9:0] ctrl;
	logic [15:0] alarm_hi;
	logic [15:0] alarm_lo;
	logic [15:0] hyst;
	logic [15:0] pump_on_sp;
	logic [15:0] pump_off_sp;
	logic [15:0] amount;
	logic [15:0] interval;
	logic [15:0] off_delay;
	logic [16:0] act_time;
	logic [15:0] duration;
	logic [15:0] span;

	logic [2:0] mode;
	logic [1:0] kind;
	logic inv;
	logic fs_en;
	logic fs_state;
	logic cmd;
	logic timed;

	logic [24:0] div_cnt;
	logic tick;
	logic [15:0] ivl_cnt;
	logic ivl_run;
	logic ivl_ev;
	logic [17:0] accum;
	logic [17:0] next_accum;
	logic acc_run;
	logic amt_ev;
	logic tod_match;
	logic tod_match_q;
	logic tod_ev;
	logic pump_lvl;
	logic pump_cmd;
	logic al_hi;
	logic al_lo;
	logic alarm;
	logic [15:0] span_hyst;
	logic [15:0] hyst_sel;
	logic fs_cond;
	logic fs_apply;
	logic func;
	logic out;
	logic [3:0] rep_mode;
	logic [31:0] status;

	rfc_pulse_if pif ();

	assign mode = ctrl[rfc_pkg::CTRL_MODE_LSB +: rfc_pkg::MODE_W];
	assign kind = ctrl[rfc_pkg::CTRL_KIND_LSB +: 2];
	assign inv = ctrl[rfc_pkg::CTRL_INV];
	assign fs_en = ctrl[rfc_pkg::CTRL_FS_EN];
	assign fs_state = ctrl[rfc_pkg::CTRL_FS_STATE];
	assign cmd = ctrl[rfc_pkg::CTRL_CMD];
	assign timed = ctrl[rfc_pkg::CTRL_TIMED];

	// Register writes
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ctrl <= rfc_pkg::CTRL_RST;
			alarm_hi <= 16'h0000;
			alarm_lo <= 16'h0000;
			hyst <= 16'h0000;
			pump_on_sp <= 16'h0000;
			pump_off_sp <= 16'h0000;
			amount <= 16'h0000;
			interval <= 16'h0000;
			off_delay <= 16'h0000;
			act_time <= 17'h00000;
			duration <= 16'h0000;
			span <= 16'h0000;
		end else if (i_wr) begin
			case (i_addr)
				rfc_pkg::OFS_CTRL: ctrl <= i_wdata[9:0];
				rfc_pkg::OFS_ALARM_HI: alarm_hi <= i_wdata[15:0];
				rfc_pkg::OFS_ALARM_LO: alarm_lo <= i_wdata[15:0];
				rfc_pkg::OFS_HYST: hyst <= i_wdata[15:0];
				rfc_pkg::OFS_PUMP_ON: pump_on_sp <= i_wdata[15:0];
				rfc_pkg::OFS_PUMP_OFF: pump_off_sp <= i_wdata[15:0];
				rfc_pkg::OFS_AMOUNT: amount <= i_wdata[15:0];
				rfc_pkg::OFS_INTERVAL: interval <= i_wdata[15:0];
				rfc_pkg::OFS_OFF_DELAY: off_delay <= i_wdata[15:0];
				rfc_pkg::OFS_ACT_TIME: act_time <= i_wdata[16:0];
				rfc_pkg::OFS_DURATION: duration <= i_wdata[15:0];
				rfc_pkg::OFS_SPAN: span <= i_wdata[15:0];
				default: begin
				end
			endcase
		end
	end

	// One-second tick divider
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			div_cnt <= 25'h0000000;
		end else if (div_cnt >= 25'(CYCLES_PER_SEC - 1)) begin
			div_cnt <= 25'h0000000;
		end else begin
			div_cnt <= div_cnt + 25'h0000001;
		end
	end

	assign tick = (div_cnt >= 25'(CYCLES_PER_SEC - 1));

	// Interval timer for sampler, elapsed time and timed setpoint
	assign ivl_run = (interval != 16'h0000) && !pif.busy
		&& ((mode == rfc_pkg::MODE_SAMP && !i_level_bad)
		|| mode == rfc_pkg::MODE_ELAPSED
		|| (mode == rfc_pkg::MODE_PUMP && timed));
	assign ivl_ev = ivl_run && tick && (ivl_cnt + 16'h0001 >= interval);

	always_ff @(posedge i_clk) begin
		if (i_rst || !ivl_run || amt_ev) begin
			ivl_cnt <= 16'h0000;
		end else if (ivl_ev) begin
			ivl_cnt <= 16'h0000;
		end else if (tick) begin
			ivl_cnt <= ivl_cnt + 16'h0001;
		end
	end

	// Quantity accumulator; counting pauses on bad status
	assign acc_run = (mode == rfc_pkg::MODE_TOT || mode == rfc_pkg::MODE_SAMP)
		&& !i_level_bad;
	always_comb begin
		next_accum = accum;
		if (i_qty_valid) begin
			next_accum = accum + {2'b00, i_qty_inc};
		end
	end
	assign amt_ev = acc_run && !pif.busy && (amount != 16'h0000)
		&& (next_accum >= {2'b00, amount});

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			accum <= 18'h00000;
		end else if (amt_ev) begin
			accum <= next_accum - {2'b00, amount};
		end else if (acc_run) begin
			accum <= next_accum;
		end
	end

	// Time of day match, one trigger per match
	assign tod_match = (i_tod_sec == act_time);
	assign tod_ev = tod_match && !tod_match_q && (mode == rfc_pkg::MODE_TOD);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			tod_match_q <= 1'b0;
		end else begin
			tod_match_q <= tod_match;
		end
	end

	// Pulse timer
	always_comb begin
		case (mode)
			rfc_pkg::MODE_TOT: pif.trig = amt_ev;
			rfc_pkg::MODE_SAMP: pif.trig = amt_ev || ivl_ev;
			rfc_pkg::MODE_TOD: pif.trig = tod_ev;
			rfc_pkg::MODE_ELAPSED: pif.trig = ivl_ev;
			rfc_pkg::MODE_PUMP: pif.trig = ivl_ev && !i_level_bad;
			default: pif.trig = 1'b0;
		endcase
	end
	assign pif.len = (mode == rfc_pkg::MODE_TOD || mode == rfc_pkg::MODE_PUMP)
		? duration : off_delay;
	assign pif.tick = tick;

	rfc_pulse u_pulse (
		.i_clk(i_clk),
		.i_rst(i_rst || mode == rfc_pkg::MODE_OFF),
		.p(pif.timer)
	);

	// Pump setpoint control
	always_ff @(posedge i_clk) begin
		if (i_rst || i_level_bad || mode != rfc_pkg::MODE_PUMP) begin
			pump_lvl <= 1'b0;
		end else if (pump_on_sp > pump_off_sp) begin
			if (i_level >= pump_on_sp) begin
				pump_lvl <= 1'b1;
			end else if (i_level <= pump_off_sp) begin
				pump_lvl <= 1'b0;
			end
		end else if (pump_on_sp < pump_off_sp) begin
			if (i_level <= pump_on_sp) begin
				pump_lvl <= 1'b1;
			end else if (i_level >= pump_off_sp) begin
				pump_lvl <= 1'b0;
			end
		end
	end

	assign pump_cmd = !i_level_bad && (pump_lvl || (timed && pif.active));

	// Process alarms
	assign span_hyst = 16'((32'(span) * rfc_pkg::BOUNDS_PCT) / rfc_pkg::PCT_DEN);
	assign hyst_sel = (kind == rfc_pkg::KIND_IN || kind == rfc_pkg::KIND_OUT)
		? span_hyst : hyst;

	rfc_alarm u_alarm (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_level(i_level),
		.i_hi(alarm_hi),
		.i_lo(alarm_lo),
		.i_hyst(hyst_sel),
		.o_hi(al_hi),
		.o_lo(al_lo)
	);

	always_comb begin
		case (kind)
			rfc_pkg::KIND_HIGH: alarm = al_hi;
			rfc_pkg::KIND_LOW: alarm = al_lo;
			rfc_pkg::KIND_IN: alarm = !(al_hi || al_lo);
			rfc_pkg::KIND_OUT: alarm = al_hi || al_lo;
			default: alarm = 1'b0;
		endcase
	end

	// Function result
	always_comb begin
		case (mode)
			rfc_pkg::MODE_ALARM: func = alarm;
			rfc_pkg::MODE_PUMP: func = pump_cmd;
			rfc_pkg::MODE_TOT: func = pif.active;
			rfc_pkg::MODE_SAMP: func = pif.active;
			rfc_pkg::MODE_TOD: func = pif.active;
			rfc_pkg::MODE_ELAPSED: func = pif.active;
			rfc_pkg::MODE_BASIC: func = cmd;
			default: func = 1'b0;
		endcase
	end

	// Fail-safe override, then polarity
	assign fs_cond = i_failsafe || i_level_bad;
	assign fs_apply = fs_cond && fs_en;
	assign out = fs_apply ? fs_state : func;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_coil <= 1'b0;
			o_icon <= 1'b0;
		end else begin
			o_coil <= out ^ inv;
			o_icon <= out;
		end
	end

	// Status and readback
	assign rep_mode = (mode == rfc_pkg::MODE_PUMP || mode == rfc_pkg::MODE_TOD)
		? rfc_pkg::MODE_APP_SETUP : {1'b0, mode};

	always_comb begin
		status = 32'h00000000;
		status[rfc_pkg::ST_COIL] = o_coil;
		status[rfc_pkg::ST_FUNC] = func;
		status[rfc_pkg::ST_BUSY] = pif.busy;
		status[rfc_pkg::ST_HI] = al_hi;
		status[rfc_pkg::ST_LO] = al_lo;
		status[rfc_pkg::ST_PUMP] = pump_cmd;
		status[rfc_pkg::ST_FS] = fs_apply;
		status[rfc_pkg::ST_MODE_LSB +: 4] = rep_mode;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst || !i_rd) begin
			o_rdata <= 32'h00000000;
		end else begin
			case (i_addr)
				rfc_pkg::OFS_CTRL: o_rdata <= {22'h000000, ctrl};
				rfc_pkg::OFS_ALARM_HI: o_rdata <= {16'h0000, alarm_hi};
				rfc_pkg::OFS_ALARM_LO: o_rdata <= {16'h0000, alarm_lo};
				rfc_pkg::OFS_HYST: o_rdata <= {16'h0000, hyst};
				rfc_pkg::OFS_PUMP_ON: o_rdata <= {16'h0000, pump_on_sp};
				rfc_pkg::OFS_PUMP_OFF: o_rdata <= {16'h0000, pump_off_sp};
				rfc_pkg::OFS_AMOUNT: o_rdata <= {16'h0000, amount};
				rfc_pkg::OFS_INTERVAL: o_rdata <= {16'h0000, interval};
				rfc_pkg::OFS_OFF_DELAY: o_rdata <= {16'h0000, off_delay};
				rfc_pkg::OFS_ACT_TIME: o_rdata <= {15'h0000, act_time};
				rfc_pkg::OFS_DURATION: o_rdata <= {16'h0000, duration};
				rfc_pkg::OFS_SPAN: o_rdata <= {16'h0000, span};
				rfc_pkg::OFS_STATUS: o_rdata <= status;
				rfc_pkg::OFS_ACCUM: o_rdata <= {14'h0000, accum};
				default: o_rdata <= 32'h00000000;
			endcase
		end
	end
endmodule
`default_nettype wire

/* test/rfc_relay_model.sv */
// Relay coil and normally open contact as seen by the load
`default_nettype none
module rfc_relay_model (
	input wire logic i_clk,
	input wire logic i_coil,
	input wire logic i_clr,
	output logic [15:0] o_count,
	output logic [15:0] o_len
);
	logic [15:0] run;
	logic contact;
	// Contact closes only while the coil is energized
	assign contact = i_coil;
	always_ff @(posedge i_clk) begin
		run <= contact ? run + 16'h1 : 16'h0;
		if (i_clr) begin
			o_count <= 16'h0;
			o_len <= 16'h0;
		end else if (!contact && run != 16'h0) begin
			o_count <= o_count + 16'h1;
			o_len <= run;
		end
	end
endmodule
`default_nettype wire

/* test/rfc_relay_ctrl_asserts.sv */
// Port assertions for the relay function controller
`default_nettype none
module rfc_relay_ctrl_chk (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic [15:0] i_level,
	input wire logic i_level_bad,
	input wire logic i_failsafe,
	input wire logic [15:0] i_qty_inc,
	input wire logic i_qty_valid,
	input wire logic [16:0] i_tod_sec,
	input wire logic o_coil,
	input wire logic o_icon
);
	logic [15:0] r [12];
	logic [1:0] age;
	logic [9:0] c;
	logic alm;
	logic pmp;
	assign c = r[0][9:0];
	assign alm = age[1] && !c[4] && !i_level_bad && c[2:0] == rfc_pkg::MODE_ALARM;
	assign pmp = age[1] && !c[4] && !c[7] && c[2:0] == rfc_pkg::MODE_PUMP && r[4] != r[5];
	// Shadow of the writable settings
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			r <= '{default: '0};
		end else if (i_wr && i_addr < 8'h30 && i_addr[1:0] == 2'h0) begin
			r[i_addr[5:2]] <= i_wdata[15:0];
		end
	end
	// Cycles since the last setting change
	always_ff @(posedge i_clk) begin
		if (i_rst || i_wr) begin
			age <= 2'h0;
		end else if (age != 2'h3) begin
			age <= age + 2'h1;
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	AST_RST_OFF: assert property ($fell(i_rst) |-> !o_coil && !o_icon)
		else $error("relay active right after reset");
	AST_POLARITY: assert property (age[1] && !c[4] |-> o_coil == (o_icon ^ c[3]))
		else $error("coil does not match icon and polarity");
	AST_BASIC: assert property (age[1] && !c[4] && c[2:0] == 3'h7 |-> o_icon == c[6])
		else $error("basic relay ignores its command");
	AST_FAILSAFE: assert property ((age[1] && c[4] && (i_failsafe || i_level_bad))[*3]
		|=> o_coil == (c[5] ^ c[3])) else $error("fail-safe state not applied");
	AST_PUMP_BAD: assert property ((pmp && i_level_bad)[*3] |=> !o_icon)
		else $error("pump kept on with bad level");
	AST_HI_SET: assert property ((alm && c[9:8] == 2'h0 && i_level >= r[1])[*3]
		|=> o_icon) else $error("high alarm not set");
	AST_HI_CLR: assert property ((alm && c[9:8] == 2'h0 && 17'(i_level) + r[3] < 17'(r[1]))[*3]
		|=> !o_icon) else $error("high alarm not cleared");
	AST_LO_SET: assert property ((alm && c[9:8] == 2'h1 && i_level <= r[2])[*3]
		|=> o_icon) else $error("low alarm not set");
	AST_LO_CLR: assert property ((alm && c[9:8] == 2'h1 && 17'(i_level) > 17'(r[2]) + r[3])[*3]
		|=> !o_icon) else $error("low alarm not cleared");
	AST_PUMP_ON: assert property ((pmp && !i_level_bad &&
		(r[4] > r[5] ? i_level >= r[4] : i_level <= r[4]))[*3] |=> o_icon)
		else $error("pump not started at on setpoint");
	AST_PUMP_OFF: assert property ((pmp &&
		(r[4] > r[5] ? i_level <= r[5] : i_level >= r[5]))[*3] |=> !o_icon)
		else $error("pump not stopped at off setpoint");
endmodule
bind rfc_relay_ctrl rfc_relay_ctrl_chk rfc_relay_ctrl_chk_i (.i_clk(i_clk), .i_rst(i_rst),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.i_level(i_level), .i_level_bad(i_level_bad), .i_failsafe(i_failsafe),
	.i_qty_inc(i_qty_inc), .i_qty_valid(i_qty_valid), .i_tod_sec(i_tod_sec),
	.o_coil(o_coil), .o_icon(o_icon));
`default_nettype wire

/* test/tb.sv */
// Self-checking bench for the relay function controller
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int CPS = 4;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [15:0] i_level = 16'h0;
	logic i_level_bad = 1'b0;
	logic i_failsafe = 1'b0;
	logic [15:0] i_qty_inc = 16'h0;
	logic i_qty_valid = 1'b0;
	logic [16:0] i_tod_sec = 17'h0;
	logic clr = 1'b1;
	logic [31:0] o_rdata;
	logic o_coil;
	logic o_icon;
	logic [15:0] cnt;
	logic [15:0] len;
	logic [31:0] v;
	logic [15:0] a;
	logic [15:0] b;
	logic [15:0] h;
	int fails = 0;
	int samples_checked = 0;
	int cycles = 0;
	always #25 i_clk = ~i_clk;
	rfc_relay_ctrl #(.CYCLES_PER_SEC(CPS)) rfc_relay_ctrl_i (.i_clk(i_clk), .i_rst(i_rst),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_level(i_level), .i_level_bad(i_level_bad), .i_failsafe(i_failsafe),
		.i_qty_inc(i_qty_inc), .i_qty_valid(i_qty_valid), .i_tod_sec(i_tod_sec),
		.o_coil(o_coil), .o_icon(o_icon));
	rfc_relay_model rfc_relay_model_i (.i_clk(i_clk), .i_coil(o_coil), .i_clr(clr),
		.o_count(cnt), .o_len(len));
	task automatic summarize();
		if (fails == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	function automatic logic [15:0] bounds_hyst(input logic [15:0] s);
		return 16'((32'(s) * 32'h2) / 32'h64);
	endfunction
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		i_addr <= ad;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic rd(input logic [7:0] ad, output logic [31:0] d);
		i_addr <= ad;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
		@(posedge i_clk);
	endtask
	task automatic io(input logic [15:0] lv, input logic c, input logic ic);
		i_level <= lv;
		repeat (5) @(posedge i_clk);
		#1 chk({30'h0, o_coil, o_icon}, {30'h0, c, ic});
		@(posedge i_clk);
	endtask
	task automatic pulse(input logic [7:0] m, input int d, input logic tot);
		clr <= 1'b1;
		@(posedge i_clk);
		clr <= 1'b0;
		wr(rfc_pkg::OFS_CTRL, 32'(m));
		i_qty_valid <= tot;
		@(posedge i_clk);
		i_qty_inc <= i_qty_inc - 16'h1;
		i_tod_sec <= i_tod_sec + 17'h1;
		@(posedge i_clk);
		i_qty_valid <= 1'b0;
		repeat (80) @(posedge i_clk);
		#1 chk(tot ? 32'(cnt) : 32'(cnt != 16'h0), 32'h1);
		chk(32'(len > 16'((d - 1) * CPS) && len <= 16'(d * CPS + 1)), 32'h1);
		@(posedge i_clk);
		wr(rfc_pkg::OFS_CTRL, 32'h0);
	endtask
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			summarize();
		end
	end
	initial begin
		void'($urandom(32'h009D6CD2));
		repeat (8) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		rd(rfc_pkg::OFS_CTRL, v);
		chk(v, 32'h0);
		wr(8'h40, $urandom());
		rd(8'h40, v);
		chk(v, 32'h0);
		for (int k = 0; k < 4; k++) begin
			wr(rfc_pkg::OFS_CTRL, {25'h0, k[0], 2'h0, k[1], rfc_pkg::MODE_BASIC});
			io(i_level, k[0] ^ k[1], k[0]);
		end
		rd(rfc_pkg::OFS_CTRL, v);
		chk(v, 32'h4F);
		wr(rfc_pkg::OFS_CTRL, 32'h57);
		for (int k = 0; k < 2; k++) begin
			{i_level_bad, i_failsafe} <= 2'(k + 1);
			repeat (4) @(posedge i_clk);
			#1 chk(32'(o_coil), 32'h0);
			@(posedge i_clk);
			{i_level_bad, i_failsafe} <= 2'h0;
			repeat (4) @(posedge i_clk);
			#1 chk(32'(o_coil), 32'h1);
			@(posedge i_clk);
		end
		a = 16'($urandom_range(60000, 1000));
		h = 16'($urandom_range(500, 1));
		wr(rfc_pkg::OFS_ALARM_HI, 32'(a));
		wr(rfc_pkg::OFS_ALARM_LO, 32'(a));
		wr(rfc_pkg::OFS_HYST, 32'(h));
		for (int k = 0; k < 2; k++) begin
			wr(rfc_pkg::OFS_CTRL, {22'h0, 2'(k), 8'h09});
			b = k ? a + h : a - h;
			io(k ? b + 16'h1 : b - 16'h1, 1'b1, 1'b0);
			io(a, 1'b0, 1'b1);
			io(b, 1'b0, 1'b1);
			io(k ? b + 16'h1 : b - 16'h1, 1'b1, 1'b0);
		end
		// Bounds alarms with the fixed span hysteresis
		b = 16'($urandom_range(20000, 1000));
		h = bounds_hyst(b);
		wr(rfc_pkg::OFS_ALARM_LO, 32'(a - 16'h03E8));
		wr(rfc_pkg::OFS_SPAN, 32'(b));
		wr(rfc_pkg::OFS_CTRL, 32'h00000301);
		io(a - 16'h01F4, 1'b0, 1'b0);
		io(a, 1'b1, 1'b1);
		io(a - h, 1'b1, 1'b1);
		io(a - h - 16'h1, 1'b0, 1'b0);
		wr(rfc_pkg::OFS_CTRL, 32'h00000201);
		io(a - 16'h03E8, 1'b0, 1'b0);
		io(a - 16'h03E8 + h, 1'b0, 1'b0);
		io(a - 16'h03E8 + h + 16'h1, 1'b1, 1'b1);
		a = 16'($urandom_range(40000, 20000));
		b = 16'($urandom_range(19000, 1000));
		h = 16'((32'(a) + 32'(b)) / 2);
		// Distinct, consistently ordered setpoints
		for (int k = 0; k < 2; k++) begin
			wr(rfc_pkg::OFS_PUMP_ON, 32'(k ? b : a));
			wr(rfc_pkg::OFS_PUMP_OFF, 32'(k ? a : b));
			wr(rfc_pkg::OFS_CTRL, 32'(rfc_pkg::MODE_PUMP));
			io(k ? a : b, 1'b0, 1'b0);
			io(h, 1'b0, 1'b0);
			io(k ? b : a, 1'b1, 1'b1);
			io(h, 1'b1, 1'b1);
		end
		rd(rfc_pkg::OFS_STATUS, v);
		chk(32'(v[11:8]), 32'(rfc_pkg::MODE_APP_SETUP));
		i_level_bad <= 1'b1;
		io(b, 1'b0, 1'b0);
		i_level_bad <= 1'b0;
		io(b, 1'b1, 1'b1);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_clk);
		#1 chk(32'(o_coil), 32'h0);
		@(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		rd(rfc_pkg::OFS_CTRL, v);
		chk(v, 32'h0);
		wr(rfc_pkg::OFS_INTERVAL, 32'h3);
		wr(rfc_pkg::OFS_OFF_DELAY, 32'h2);
		pulse(8'(rfc_pkg::MODE_ELAPSED), 2, 1'b0);
		wr(rfc_pkg::OFS_INTERVAL, 32'h2);
		pulse(8'(rfc_pkg::MODE_SAMP), 2, 1'b0);
		a = 16'($urandom_range(200, 2));
		wr(rfc_pkg::OFS_AMOUNT, 32'(a));
		wr(rfc_pkg::OFS_OFF_DELAY, 32'h1);
		i_qty_inc <= a;
		pulse(8'(rfc_pkg::MODE_TOT), 1, 1'b1);
		// Time of day steps onto the activation time inside the pulse task
		i_tod_sec <= 17'($urandom_range(86398, 0));
		@(posedge i_clk);
		wr(rfc_pkg::OFS_ACT_TIME, 32'(i_tod_sec) + 32'h1);
		wr(rfc_pkg::OFS_DURATION, 32'h2);
		pulse(8'(rfc_pkg::MODE_TOD), 2, 1'b0);
		// Timed pump setpoint, interval and duration of two seconds
		pulse(8'h82, 2, 1'b0);
		summarize();
	end
endmodule
`default_nettype wire
